// File: mfs_regs.svh
`ifndef MFS_REGS_SVH
`define MFS_REGS_SVH

// Register offsets
`define MFS_ADDR_EVENT    8'h11
`define MFS_ADDR_FLAGS    8'h16
`define MFS_ADDR_AMP_LO   8'h17
`define MFS_ADDR_AMP_HI   8'h18
`define MFS_ADDR_CHG      8'h90
`define MFS_ADDR_TUNE     8'h91
`define MFS_ADDR_SW_CFG   8'ha0
`define MFS_ADDR_SW_PROX  8'ha1
`define MFS_ADDR_SW_TOUCH 8'ha2

// Field positions
`define MFS_EV_FIELD      2
`define MFS_FL_POLARITY   0
`define MFS_FL_PROX       1
`define MFS_FL_TOUCH      2
`define MFS_CFG_SWITCH    0
`define MFS_CFG_LINEAR    1

// Reset values
`define MFS_RST_CHG       8'h00
`define MFS_RST_TUNE      8'h00
`define MFS_RST_SW_CFG    8'h00
`define MFS_RST_PROX      8'h10
`define MFS_RST_TOUCH     8'h40

// Timing: clock period and base conversion interval
`define MFS_CLK_NS        10
`define MFS_RATE_BASE_NS  10000
`define MFS_RATE_BASE_CYC (`MFS_RATE_BASE_NS / `MFS_CLK_NS)

// Numerator of the inverse linearizer
`define MFS_INV_NUM       24'hff_ffff

`endif

// File: mfs_pkg.sv
`default_nettype none
package mfs_pkg;
  // Conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    mfs_st_idle   = 3'b001,
    mfs_st_divide = 3'b010,
    mfs_st_commit = 3'b100
  } mfs_state_type;
endpackage
`default_nettype wire

// File: mfs_rate_timer.sv
`default_nettype none
`include "mfs_regs.svh"
module mfs_rate_timer #(
  parameter int unsigned BASE_CYC = `MFS_RATE_BASE_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] divider,
  output logic            tick
);
  logic [31:0] count;   // Cycles since last tick
  logic [31:0] limit;   // Interval, doubled per divider step

  // Larger divider gives a slower conversion rate
  assign limit = BASE_CYC << divider;

  // Interval counter; a divider change takes effect at once
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count + 32'h0000_0001 >= limit) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: mfs_recip.sv
`default_nettype none
`include "mfs_regs.svh"
module mfs_recip (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] divisor,
  output logic             busy,
  output logic             done,
  output logic [15:0]      quotient
);
  logic [16:0] rem;      // Partial remainder
  logic [23:0] num;      // Dividend bits still to shift in
  logic [23:0] q;        // Quotient so far
  logic [4:0]  cnt;      // Steps left
  logic [16:0] trial;    // Remainder with next bit
  logic        fits;     // Divisor fits in trial
  logic [23:0] next_q;

  assign trial  = {rem[15:0], num[23]};
  assign fits   = trial >= {1'b0, divisor};
  assign next_q = {q[22:0], fits};

  // Restoring division, one bit per cycle; divisor must hold still while busy
  always_ff @(posedge mclk) begin
    if (rst) begin
      rem <= 17'h0_0000;
      num <= 24'h00_0000;
      q   <= 24'h00_0000;
      cnt <= 5'h00;
    end else if (start && !busy) begin
      rem <= 17'h0_0000;
      num <= `MFS_INV_NUM;
      q   <= 24'h00_0000;
      cnt <= 5'h18;
    end else if (busy) begin
      rem <= fits ? trial - {1'b0, divisor} : trial;
      num <= {num[22:0], 1'b0};
      q   <= next_q;
      cnt <= cnt - 5'h01;
    end
  end

  // Handshake and saturated result; zero divisor saturates too
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      quotient <= 16'h0000;
    end else begin
      done <= busy && cnt == 5'h01;
      if (start && !busy) begin
        busy <= 1'b1;
      end else if (busy && cnt == 5'h01) begin
        busy     <= 1'b0;
        quotient <= (|next_q[23:16]) ? 16'hffff : next_q[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// File: mfs_field_ui.sv
`default_nettype none
`include "mfs_regs.svh"
// Operation
// - Channel four positive, channel five negative
// - Differential value feeds every field interface
// - General and switch field interfaces offered
// - Proximity and touch thresholds, separate outputs
// - Optional inverse linearization of output
// - Flags hold proximity, touch, polarity
// - Summary bit two toggles per detection
// - One summary bit for field output
// - Sixteen-bit amplitude, low then high
// - Charge divider field alone sets rate
// - Switch settings and thresholds host writable
module mfs_field_ui
  import mfs_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYC = `MFS_RATE_BASE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic [7:0]  other_events,
  input  wire logic        conv_done,
  input  wire logic [15:0] positive_field_channel,
  input  wire logic [15:0] negative_field_channel,
  output logic             conv_start,
  output logic [7:0]       charge_tuning,
  output logic [7:0]       tuning_base_target,
  output logic             field_proximity_output,
  output logic             field_touch_output,
  output logic             field_polarity
);
  mfs_state_type state;               // Conversion sequencer
  logic [7:0]    switch_cfg;          // Switch interface settings
  logic [7:0]    prox_thr;            // Switch proximity threshold
  logic [7:0]    touch_thr;           // Switch touch threshold
  logic [15:0]   mag;                 // Magnitude of captured difference
  logic          mag_neg;             // Captured sign, set for south
  logic [15:0]   amplitude;           // Reported amplitude
  logic [7:0]    flags;               // Reported flag byte
  logic          field_event;         // Toggling summary bit
  logic [16:0]   next_diff;           // Positive minus negative
  logic [15:0]   next_amp;            // Amplitude to commit
  logic          next_prox;
  logic          next_touch;
  logic          next_detect;         // Interface made a detection
  logic          switch_mode;
  logic          linear_mode;
  logic          recip_start;
  logic          recip_done;
  logic [15:0]   recip_q;

  assign switch_mode = switch_cfg[`MFS_CFG_SWITCH];
  assign linear_mode = switch_cfg[`MFS_CFG_LINEAR];

  // Rate timer paced by the charge divider field
  mfs_rate_timer #(
    .BASE_CYC (RATE_BASE_CYC)
  ) u_rate (
    .mclk    (mclk),
    .rst     (rst),
    .divider (charge_tuning[3:0]),
    .tick    (conv_start)
  );

  // Inverse calculator for the linearized output
  mfs_recip u_recip (
    .mclk     (mclk),
    .rst      (rst),
    .start    (recip_start),
    .divisor  (mag),
    .busy     (),
    .done     (recip_done),
    .quotient (recip_q)
  );

  // Host writes to configuration; read-only offsets ignore writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      charge_tuning      <= `MFS_RST_CHG;
      tuning_base_target <= `MFS_RST_TUNE;
      switch_cfg         <= `MFS_RST_SW_CFG;
      prox_thr           <= `MFS_RST_PROX;
      touch_thr          <= `MFS_RST_TOUCH;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `MFS_ADDR_CHG:      charge_tuning      <= reg_wdata;
        `MFS_ADDR_TUNE:     tuning_base_target <= reg_wdata;
        `MFS_ADDR_SW_CFG:   switch_cfg         <= reg_wdata;
        `MFS_ADDR_SW_PROX:  prox_thr           <= reg_wdata;
        `MFS_ADDR_SW_TOUCH: touch_thr          <= reg_wdata;
        default: begin
          // Read-only or unmapped: nothing stored
        end
      endcase
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        // One summary bit belongs to the field logic
        `MFS_ADDR_EVENT:    reg_rdata <= {other_events[7:3], field_event, other_events[1:0]};
        `MFS_ADDR_FLAGS:    reg_rdata <= flags;
        `MFS_ADDR_AMP_LO:   reg_rdata <= amplitude[7:0];
        `MFS_ADDR_AMP_HI:   reg_rdata <= amplitude[15:8];
        `MFS_ADDR_CHG:      reg_rdata <= charge_tuning;
        `MFS_ADDR_TUNE:     reg_rdata <= tuning_base_target;
        `MFS_ADDR_SW_CFG:   reg_rdata <= switch_cfg;
        `MFS_ADDR_SW_PROX:  reg_rdata <= prox_thr;
        `MFS_ADDR_SW_TOUCH: reg_rdata <= touch_thr;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // Differential value: both inputs widened so the sign survives
  assign next_diff = {1'b0, positive_field_channel} - {1'b0, negative_field_channel};

  // Sequencer: capture, optional inverse, then one commit cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      state       <= mfs_st_idle;
      mag         <= 16'h0000;
      mag_neg     <= 1'b0;
      recip_start <= 1'b0;
    end else begin
      recip_start <= 1'b0;
      unique case (state)
        mfs_st_idle: begin
          if (conv_done) begin
            mag_neg <= next_diff[16];
            // Magnitude never exceeds 16 bits
            mag     <= next_diff[16] ? 16'(-next_diff) : next_diff[15:0];
            if (linear_mode) begin
              recip_start <= 1'b1;
              state       <= mfs_st_divide;
            end else begin
              state <= mfs_st_commit;
            end
          end
        end
        mfs_st_divide: begin
          // Conversions arriving meanwhile are dropped, not queued
          if (recip_done) begin
            state <= mfs_st_commit;
          end
        end
        mfs_st_commit: begin
          state <= mfs_st_idle;
        end
      endcase
    end
  end

  // Amplitude source and threshold comparison
  always_comb begin
    next_amp    = linear_mode ? recip_q : mag;
    next_prox   = 1'b0;
    next_touch  = 1'b0;
    next_detect = 1'b0;
    if (switch_mode) begin
      // Switch interface: two levels on the amplitude's upper byte
      next_prox   = next_amp[15:8] >= prox_thr;
      next_touch  = next_amp[15:8] >= touch_thr;
      next_detect = next_prox != flags[`MFS_FL_PROX] || next_touch != flags[`MFS_FL_TOUCH];
    end else begin
      // General interface: a polarity reversal counts as detection
      next_detect = mag != 16'h0000 && mag_neg != flags[`MFS_FL_POLARITY];
    end
  end

  // All results land in the same cycle so a read is consistent
  always_ff @(posedge mclk) begin
    if (rst) begin
      amplitude              <= 16'h0000;
      flags                  <= 8'h00;
      field_event            <= 1'b0;
      field_proximity_output <= 1'b0;
      field_touch_output     <= 1'b0;
      field_polarity         <= 1'b0;
    end else if (state == mfs_st_commit) begin
      amplitude                <= next_amp;
      flags                    <= 8'h00;
      flags[`MFS_FL_POLARITY]  <= mag_neg;
      flags[`MFS_FL_PROX]      <= next_prox;
      flags[`MFS_FL_TOUCH]     <= next_touch;
      field_proximity_output   <= next_prox;
      field_touch_output       <= next_touch;
      field_polarity           <= mag_neg;
      field_event              <= field_event ^ next_detect;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_capture;
    state == mfs_st_idle && conv_done;
  endsequence

  sequence s_linear_start;
    s_capture ##0 linear_mode;
  endsequence

  a_diff_capture: assert property (
    s_capture |=> mag == (($past(positive_field_channel) >= $past(negative_field_channel)) ?
      $past(positive_field_channel) - $past(negative_field_channel) :
      $past(negative_field_channel) - $past(positive_field_channel)))
    else $error("captured magnitude differs from channel difference");

  a_linear_bound: assert property (
    s_linear_start |=> state == mfs_st_divide ##[1:30] state == mfs_st_commit)
    else $error("inverse calculation did not finish in time");

  a_event_toggle: assert property (
    state == mfs_st_commit && next_detect |=> field_event != $past(field_event))
    else $error("summary bit did not toggle on detection");

  a_event_quiet: assert property (
    state != mfs_st_commit |=> $stable(field_event))
    else $error("summary bit moved outside a commit");

  a_results_together: assert property (
    $changed(amplitude) || $changed(flags) |-> $past(state) == mfs_st_commit)
    else $error("results changed outside the commit cycle");

  a_touch_level: assert property (
    state == mfs_st_commit && switch_mode |=>
      field_touch_output == (amplitude[15:8] >= $past(touch_thr)))
    else $error("touch output disagrees with threshold");

  a_flag_pins: assert property (
    field_proximity_output == flags[`MFS_FL_PROX] && field_touch_output == flags[`MFS_FL_TOUCH])
    else $error("flag register and output pins disagree");

  a_amp_readonly: assert property (
    reg_wr && reg_addr == `MFS_ADDR_AMP_LO && state != mfs_st_commit |=> $stable(amplitude))
    else $error("write changed read-only amplitude");

  a_threshold_write: assert property (
    reg_wr && reg_addr == `MFS_ADDR_SW_PROX |=> prox_thr == $past(reg_wdata))
    else $error("proximity threshold write lost");

  // The one cycle in which every result lands
  sequence s_commit;
    state == mfs_st_commit;
  endsequence

  // A plain conversion skips the divider and commits at once
  a_plain_commit: assert property (
    s_capture ##0 !linear_mode |=> state == mfs_st_commit)
    else $error("plain conversion skipped the commit cycle");

  // The general interface never raises the switch levels
  a_general_levels: assert property (
    s_commit ##0 !switch_mode |=> !field_proximity_output && !field_touch_output)
    else $error("general interface raised a switch level");

  a_prox_level: assert property (
    s_commit ##0 switch_mode |=>
      field_proximity_output == (amplitude[15:8] >= $past(prox_thr)))
    else $error("proximity output disagrees with threshold");

  a_polarity_flag: assert property (
    s_commit |=> flags[`MFS_FL_POLARITY] == $past(mag_neg) && field_polarity == $past(mag_neg))
    else $error("polarity flag disagrees with captured sign");

  // No detection, no toggle: a host polling the bit sees only real events
  a_event_hold: assert property (
    s_commit ##0 !next_detect |=> $stable(field_event))
    else $error("summary bit toggled without a detection");

  // Read path carries the live state, not a stale copy
  a_summary_read: assert property (
    reg_rd && reg_addr == `MFS_ADDR_EVENT |=> reg_rdata[`MFS_EV_FIELD] == $past(field_event))
    else $error("summary read lost the field bit");

  a_flags_read: assert property (
    reg_rd && reg_addr == `MFS_ADDR_FLAGS |=> reg_rdata == $past(flags))
    else $error("flag register read wrong");

  a_amp_read: assert property (
    reg_rd && reg_addr == `MFS_ADDR_AMP_HI |=> reg_rdata == $past(amplitude[15:8]))
    else $error("amplitude high byte read wrong");

  // The divider field drives the rate timer from the next cycle on
  a_charge_write: assert property (
    reg_wr && reg_addr == `MFS_ADDR_CHG |=> charge_tuning == $past(reg_wdata))
    else $error("charge and tuning write lost");
endmodule
`default_nettype wire

// File: mfs_front_model.sv
`default_nettype none
module mfs_front_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        answer_en,
  input  wire logic        conv_start,
  input  wire logic [7:0]  lat,
  input  wire logic [15:0] pos_val,
  input  wire logic [15:0] neg_val,
  output logic             conv_done,
  output logic [15:0]      pos_out,
  output logic [15:0]      neg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Answer an armed start request after lat cycles
  initial begin
    conv_done = 1'b0;
    pos_out   = 16'h5a5a;
    neg_out   = 16'ha5a5;
    forever begin
      @(posedge mclk);
      if (!rst && answer_en && conv_start) begin
        repeat (lat) @(posedge mclk);
        conv_done <= 1'b1;
        pos_out   <= pos_val;
        neg_out   <= neg_val;
        @(posedge mclk);
        // Counts are stale after the pulse, so show their inverse
        conv_done <= 1'b0;
        pos_out   <= ~pos_val;
        neg_out   <= ~neg_val;
      end
    end
  end
endmodule
`default_nettype wire

// File: mfs_field_ui_test.sv
`default_nettype none
`include "mfs_regs.svh"
module mfs_field_ui_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RATE = 4;  // Short base interval keeps the run brief
  logic        mclk, rst, reg_wr, reg_rd, conv_done, conv_start, ans_en;
  logic        prox, touch, pol, prox_e, touch_e, pol_e, ev_e;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, other, chg, tune, lat, cfg;
  logic [15:0] pos_val, neg_val, pos_ch, neg_ch;
  logic [31:0] seed;
  int          err_count, num_checks, k;

  mfs_field_ui #(.RATE_BASE_CYC(RATE)) dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .other_events(other), .conv_done(conv_done),
    .positive_field_channel(pos_ch), .negative_field_channel(neg_ch), .conv_start(conv_start),
    .charge_tuning(chg), .tuning_base_target(tune), .field_proximity_output(prox),
    .field_touch_output(touch), .field_polarity(pol));

  mfs_front_model fe (
    .mclk(mclk), .rst(rst), .answer_en(ans_en), .conv_start(conv_start), .lat(lat),
    .pos_val(pos_val), .neg_val(neg_val), .conv_done(conv_done), .pos_out(pos_ch), .neg_out(neg_ch));

  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reported amplitude: magnitude, or saturated inverse when linearized
  function automatic logic [15:0] exp_amp(input logic lin, input logic [15:0] p, input logic [15:0] n);
    logic [15:0] m;
    logic [23:0] q;
    m = (p >= n) ? p - n : n - p;
    if (!lin) return m;
    if (m == 16'h0) return 16'hffff;
    q = `MFS_INV_NUM / m;
    return (q > 24'h00ffff) ? 16'hffff : q[15:0];
  endfunction

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, s);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // Read data is loaded at the strobe edge, so look half a cycle later
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    check(what, 16'(e), 16'(reg_rdata));
  endtask

  task automatic wait_start();
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (conv_start !== 1'b1 && k < 3000);
  endtask

  // One armed conversion, then pins and registers against the expectation
  task automatic convert(input logic [15:0] p, input logic [15:0] n);
    logic [15:0] a;
    logic        np, nt, det;
    void'(rnd());
    pos_val = p;
    neg_val = n;
    lat     = seed[0] ? 8'h01 : 8'h14;  // Prompt or slow answer
    other   = seed[15:8];
    ans_en  = 1'b1;
    k       = 0;
    while (conv_done !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    ans_en = 1'b0;
    check("conv_done", 16'h1, 16'(conv_done));
    repeat (40) @(negedge mclk);
    a   = exp_amp(cfg[`MFS_CFG_LINEAR], p, n);
    np  = cfg[`MFS_CFG_SWITCH] && (a[15:8] >= 8'h20);
    nt  = cfg[`MFS_CFG_SWITCH] && (a[15:8] >= 8'h60);
    det = cfg[`MFS_CFG_SWITCH] ? (np != prox_e || nt != touch_e) : (p != n && (n > p) != pol_e);
    ev_e ^= det;
    prox_e  = np;
    touch_e = nt;
    pol_e   = n > p;
    check("prox pin", 16'(np), 16'(prox));
    check("touch pin", 16'(nt), 16'(touch));
    check("polarity pin", 16'(pol_e), 16'(pol));
    rchk("flags", `MFS_ADDR_FLAGS, {5'h0, nt, np, pol_e});
    rchk("amp low", `MFS_ADDR_AMP_LO, a[7:0]);
    rchk("amp high", `MFS_ADDR_AMP_HI, a[15:8]);
    rchk("summary", `MFS_ADDR_EVENT, {other[7:3], ev_e, other[1:0]});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run of about 32k cycles
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    summarize();
  end

  initial begin
    rst        = 1'b1;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    other      = 8'h00;
    ans_en     = 1'b0;
    lat        = 8'h01;
    pos_val    = 16'h0;
    neg_val    = 16'h0;
    cfg        = 8'h00;
    {prox_e, touch_e, pol_e, ev_e} = 4'h0;
    err_count  = 0;
    num_checks = 0;
    seed       = 32'h0000_0063;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rchk("chg reset", `MFS_ADDR_CHG, `MFS_RST_CHG);
    rchk("tune reset", `MFS_ADDR_TUNE, `MFS_RST_TUNE);
    rchk("cfg reset", `MFS_ADDR_SW_CFG, `MFS_RST_SW_CFG);
    rchk("prox thr reset", `MFS_ADDR_SW_PROX, `MFS_RST_PROX);
    rchk("touch thr reset", `MFS_ADDR_SW_TOUCH, `MFS_RST_TOUCH);
    wr(`MFS_ADDR_AMP_LO, 8'hff);
    rchk("amp low read-only", `MFS_ADDR_AMP_LO, 8'h00);
    rchk("unmapped", 8'h55, 8'h00);
    // Full automatic tuning, target above base, proximity below touch
    wr(`MFS_ADDR_CHG, 8'hf8);
    wr(`MFS_ADDR_TUNE, 8'h93);
    wr(`MFS_ADDR_SW_PROX, 8'h20);
    wr(`MFS_ADDR_SW_TOUCH, 8'h60);
    rchk("chg", `MFS_ADDR_CHG, 8'hf8);
    rchk("tune", `MFS_ADDR_TUNE, 8'h93);
    rchk("prox thr", `MFS_ADDR_SW_PROX, 8'h20);
    rchk("touch thr", `MFS_ADDR_SW_TOUCH, 8'h60);
    check("charge pins", 16'h00f8, 16'(chg));
    check("tune pins", 16'h0093, 16'(tune));
    // The first gap starts mid-interval, so it runs short
    repeat (3) wait_start();
    check("start interval", 16'(RATE << 8), 16'(k));
    // General and switch interfaces, each plain and linearized
    for (int m = 0; m < 4; m++) begin
      cfg = 8'(m);
      wr(`MFS_ADDR_SW_CFG, cfg);
      convert(16'h2100, 16'h0100);
      convert(16'h0100, 16'h6100);
      convert(16'h0005, 16'h0004);
      for (int i = 0; i < 4; i++) begin
        void'(rnd());
        convert({1'b0, seed[14:0]}, {1'b0, seed[30:16]});
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
